/* tmx_defines.svh */
// Offsets, field positions, reset values and counts for the trace aux block.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef TMX_DEFINES_SVH
`define TMX_DEFINES_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define TMX_OFS_EXTSEL 12'h000
`define TMX_OFS_AUX 12'h004
`define TMX_OFS_PDC 12'h008
`define TMX_OFS_ITCTRL 12'h00C
`define TMX_OFS_MISCOUT 12'h010
`define TMX_OFS_MISCIN 12'h014
`define TMX_OFS_TRIG 12'h018
`define TMX_OFS_DATA 12'h01C
`define TMX_OFS_CTRLIN 12'h020
`define TMX_OFS_CTRLOUT 12'h024
// ****************************************
// Fields and reset values
// ****************************************
`define TMX_SEL0_LSB 0
`define TMX_SEL1_LSB 8
`define TMX_SEL_W 7
`define TMX_AUX_FORCE_TS 5
`define TMX_AUX_DELAY_SYNC 4
`define TMX_AUX_DIS_WP 3
`define TMX_AUX_DIS_EXC_TS 2
`define TMX_AUX_DIS_BAR_TS 1
`define TMX_AUX_DIS_FOVF 0
`define TMX_PDC_PWRUP 3
`define TMX_MISCOUT_LSB 8
`define TMX_EXTSEL_RST 32'h0000_0000
`define TMX_AUX_RST 6'h00
`define TMX_EXT_BUS_W 88
`define TMX_WP_GAP_BYTES 16'h1000
`endif

/* tmx_pkg.sv */
// Types shared by the trace aux block.
// Assumes tmx_defines.svh is on the include path.
package tmx_pkg;
  typedef logic [31:0] tmx_word_type;
  typedef enum logic [3:0] {
    TMX_R_EXTSEL = 4'h0,
    TMX_R_AUX = 4'h1,
    TMX_R_PDC = 4'h2,
    TMX_R_ITCTRL = 4'h3,
    TMX_R_MISCOUT = 4'h4,
    TMX_R_MISCIN = 4'h5,
    TMX_R_TRIG = 4'h6,
    TMX_R_DATA = 4'h7,
    TMX_R_CTRLIN = 4'h8,
    TMX_R_CTRLOUT = 4'h9,
    TMX_R_NONE = 4'hF
  } tmx_reg_type;
endpackage : tmx_pkg

/* tmx_trace_aux.sv */
// Register-controlled aux part of the program trace macrocell: input
// selection, packet policy, power-up request and integration test muxing.
// Assumes an APB master on CLK and functional trace logic feeding FN_ inputs.
//
// Behaviour
// - Two 7-bit input selectors, bits 14:8, 6:0.
// - Force bit inserts timestamps despite high activity.
// - Sync-delay set postpones sync while busy.
// - Waypoint update past 4096 bytes unless disabled.
// - Timestamp on exception entry/return unless disabled.
// - Timestamp on barrier unless disabled.
// - Early sync forces overflow unless disabled.
// - Power-up request output follows its bit.
// - Integration registers act only in integration mode.
// - Misc out bits 9:8 drive external outputs.
// - Misc in bits 3:0 read external inputs.
// - Trigger register bit 0 drives trigger output.
// - Data register bits 4:0 drive bus bits.
// - Ctrl in reads flush-valid bit 1, ready bit 0.
// - Integration mode bit 0, cleared by reset.
`include "tmx_defines.svh"
module tmx_trace_aux
  import tmx_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [87:0] EXT_IN_BUS,
  output logic [1:0] SELECTED_INPUTS,
  input wire logic TRACE_BUSY,
  input wire logic TS_REQ,
  input wire logic SYNC_REQ,
  input wire logic SYNC_PENDING,
  input wire logic FIFO_FULL,
  input wire logic EXC_EVENT,
  input wire logic DBG_ENTRY,
  input wire logic BARRIER_EVENT,
  input wire logic [15:0] WP_GAP,
  output logic TS_INSERT,
  output logic SYNC_INSERT,
  output logic WP_UPDATE,
  output logic OVERFLOW_ENTER,
  output logic CORE_POWER_UP_REQUEST,
  input wire logic [1:0] FN_EXT_OUT,
  input wire logic FN_TRIGGER,
  input wire logic [31:0] FN_BUS_DATA,
  input wire logic FN_BUS_VALID,
  input wire logic [3:0] TRACE_EXTERNAL_INPUTS,
  input wire logic TRACE_BUS_FLUSH_VALID,
  input wire logic TRACE_BUS_READY,
  output logic [1:0] TRACE_EXTERNAL_OUTPUTS,
  output logic TRACE_TRIGGER_OUT,
  output logic [31:0] TRACE_BUS_DATA,
  output logic TRACE_BUS_VALID
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic tmx_reg_type decode(input logic [11:0] a);
    case (a)
      `TMX_OFS_EXTSEL: decode = TMX_R_EXTSEL;
      `TMX_OFS_AUX: decode = TMX_R_AUX;
      `TMX_OFS_PDC: decode = TMX_R_PDC;
      `TMX_OFS_ITCTRL: decode = TMX_R_ITCTRL;
      `TMX_OFS_MISCOUT: decode = TMX_R_MISCOUT;
      `TMX_OFS_MISCIN: decode = TMX_R_MISCIN;
      `TMX_OFS_TRIG: decode = TMX_R_TRIG;
      `TMX_OFS_DATA: decode = TMX_R_DATA;
      `TMX_OFS_CTRLIN: decode = TMX_R_CTRLIN;
      `TMX_OFS_CTRLOUT: decode = TMX_R_CTRLOUT;
      default: decode = TMX_R_NONE;
    endcase
  endfunction : decode

  // Selector codes beyond the bus width pick a constant zero.
  function automatic logic pick(input logic [87:0] bus, input logic [6:0] s);
    if (s < 7'(`TMX_EXT_BUS_W))
    begin
      pick = bus[s];
    end
    else
    begin
      pick = 1'b0;
    end
  endfunction : pick

  // ****************************************
  // Register state
  // ****************************************
  logic [6:0] sel0_q;
  logic [6:0] sel1_q;
  logic [5:0] aux_q;
  logic pwrup_q;
  logic itmode_q;
  logic [1:0] misc_out_q;
  logic trig_q;
  logic [4:0] data_q;
  logic valid_q;
  tmx_reg_type wr_reg;
  tmx_reg_type rd_reg;
  logic wr_en;
  tmx_word_type rd_d;

  assign wr_en = PSEL && PENABLE && PWRITE;
  assign wr_reg = decode(PADDR);
  assign rd_reg = decode(PADDR);
  // Zero wait states: read data is staged in the setup cycle.
  assign PREADY = 1'b1;

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      sel0_q <= 7'h00;
      sel1_q <= 7'h00;
    end
    else if (wr_en && wr_reg == TMX_R_EXTSEL)
    begin
      sel0_q <= PWDATA[`TMX_SEL0_LSB +: `TMX_SEL_W];
      sel1_q <= PWDATA[`TMX_SEL1_LSB +: `TMX_SEL_W];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      aux_q <= `TMX_AUX_RST;
    end
    else if (wr_en && wr_reg == TMX_R_AUX)
    begin
      aux_q <= PWDATA[5:0];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      pwrup_q <= 1'b0;
    end
    else if (wr_en && wr_reg == TMX_R_PDC)
    begin
      pwrup_q <= PWDATA[`TMX_PDC_PWRUP];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      itmode_q <= 1'b0;
    end
    else if (wr_en && wr_reg == TMX_R_ITCTRL)
    begin
      itmode_q <= PWDATA[0];
    end
  end

  // Output integration values are kept even outside integration mode,
  // so they reach the outputs on the clock edge after the mode bit is set.
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      misc_out_q <= 2'h0;
      trig_q <= 1'b0;
      data_q <= 5'h00;
      valid_q <= 1'b0;
    end
    else if (wr_en)
    begin
      case (wr_reg)
        TMX_R_MISCOUT: misc_out_q <= PWDATA[`TMX_MISCOUT_LSB +: 2];
        TMX_R_TRIG: trig_q <= PWDATA[0];
        TMX_R_DATA: data_q <= PWDATA[4:0];
        TMX_R_CTRLOUT: valid_q <= PWDATA[0];
        default: valid_q <= valid_q;
      endcase
    end
  end

  // ****************************************
  // APB read path
  // ****************************************
  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (rd_reg)
      TMX_R_EXTSEL: rd_d = {17'h00000, sel1_q, 1'b0, sel0_q};
      TMX_R_AUX: rd_d = {26'h0000000, aux_q};
      TMX_R_PDC: rd_d = {28'h0000000, pwrup_q, 3'h0};
      TMX_R_ITCTRL: rd_d = {31'h00000000, itmode_q};
      TMX_R_MISCIN: rd_d = itmode_q ? {28'h0000000, TRACE_EXTERNAL_INPUTS} : 32'h0;
      TMX_R_CTRLIN: rd_d = itmode_q ? {30'h0, TRACE_BUS_FLUSH_VALID, TRACE_BUS_READY} : 32'h0;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else if (PSEL && !PENABLE)
    begin
      PRDATA <= PWRITE ? 32'h0000_0000 : rd_d;
      PSLVERR <= (rd_reg == TMX_R_NONE);
    end
  end

  // ****************************************
  // Input selection and packet policy
  // ****************************************
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      SELECTED_INPUTS <= 2'h0;
    end
    else
    begin
      SELECTED_INPUTS <= {pick(EXT_IN_BUS, sel1_q), pick(EXT_IN_BUS, sel0_q)};
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      TS_INSERT <= 1'b0;
      SYNC_INSERT <= 1'b0;
      WP_UPDATE <= 1'b0;
      OVERFLOW_ENTER <= 1'b0;
    end
    else
    begin
      TS_INSERT <= (TS_REQ && (aux_q[`TMX_AUX_FORCE_TS] || !TRACE_BUSY))
        || (EXC_EVENT && !aux_q[`TMX_AUX_DIS_EXC_TS])
        || (BARRIER_EVENT && !aux_q[`TMX_AUX_DIS_BAR_TS]);
      SYNC_INSERT <= SYNC_REQ && !(aux_q[`TMX_AUX_DELAY_SYNC] && TRACE_BUSY);
      WP_UPDATE <= (WP_GAP > `TMX_WP_GAP_BYTES && !aux_q[`TMX_AUX_DIS_WP])
        || EXC_EVENT || DBG_ENTRY;
      OVERFLOW_ENTER <= FIFO_FULL
        || (SYNC_REQ && SYNC_PENDING && !aux_q[`TMX_AUX_DIS_FOVF]);
    end
  end

  // ****************************************
  // Output muxing
  // ****************************************
  // The mux is registered so the trace bus never sees a glitch when
  // software flips the mode bit. Valid is driven from its own register
  // so test software can raise it before sampling ready.
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      TRACE_EXTERNAL_OUTPUTS <= 2'h0;
      TRACE_TRIGGER_OUT <= 1'b0;
      TRACE_BUS_DATA <= 32'h0000_0000;
      TRACE_BUS_VALID <= 1'b0;
    end
    else if (itmode_q)
    begin
      TRACE_EXTERNAL_OUTPUTS <= misc_out_q;
      TRACE_TRIGGER_OUT <= trig_q;
      TRACE_BUS_DATA <= {data_q[4], 7'h00, data_q[3], 7'h00, data_q[2], 7'h00,
        data_q[1], 6'h00, data_q[0]};
      TRACE_BUS_VALID <= valid_q;
    end
    else
    begin
      TRACE_EXTERNAL_OUTPUTS <= FN_EXT_OUT;
      TRACE_TRIGGER_OUT <= FN_TRIGGER;
      TRACE_BUS_DATA <= FN_BUS_DATA;
      TRACE_BUS_VALID <= FN_BUS_VALID;
    end
  end

  assign CORE_POWER_UP_REQUEST = pwrup_q;

  // ****************************************
  // Assertions
  // ****************************************
  a_pwrup_follow: assert property (@(posedge CLK) disable iff (!RST_B)
    wr_en && wr_reg == TMX_R_PDC |=> CORE_POWER_UP_REQUEST == $past(PWDATA[3]))
    else $error("Power-up request does not follow its bit.");

  a_itmode_set: assert property (@(posedge CLK) disable iff (!RST_B)
    wr_en && wr_reg == TMX_R_ITCTRL && PWDATA[0] |=> itmode_q)
    else $error("Integration mode not entered.");

  a_misc_drive: assert property (@(posedge CLK) disable iff (!RST_B)
    itmode_q && $stable(itmode_q) |=> TRACE_EXTERNAL_OUTPUTS == $past(misc_out_q))
    else $error("External outputs not driven from misc register.");

  a_func_drive: assert property (@(posedge CLK) disable iff (!RST_B)
    !itmode_q |=> TRACE_TRIGGER_OUT == $past(FN_TRIGGER))
    else $error("Trigger not functional outside integration mode.");

  a_data_map: assert property (@(posedge CLK) disable iff (!RST_B)
    itmode_q |=> TRACE_BUS_DATA[31] == $past(data_q[4]) && TRACE_BUS_DATA[0] == $past(data_q[0]))
    else $error("Trace data bit mapping wrong.");

  a_miscin_read: assert property (@(posedge CLK) disable iff (!RST_B)
    PSEL && !PENABLE && !PWRITE && rd_reg == TMX_R_MISCIN
    |=> PRDATA == (($past(itmode_q)) ? {28'h0, $past(TRACE_EXTERNAL_INPUTS)} : 32'h0))
    else $error("Misc input read wrong.");

  a_sync_delay: assert property (@(posedge CLK) disable iff (!RST_B)
    SYNC_REQ && TRACE_BUSY && aux_q[4] |=> !SYNC_INSERT)
    else $error("Sync inserted while delayed.");

  a_force_ovf: assert property (@(posedge CLK) disable iff (!RST_B)
    SYNC_REQ && SYNC_PENDING && !aux_q[0] |=> OVERFLOW_ENTER)
    else $error("Forced overflow missing.");

  a_reserved_zero: assert property (@(posedge CLK) disable iff (!RST_B)
    PSEL && !PENABLE && rd_reg == TMX_R_AUX |=> PRDATA[31:6] == 26'h0)
    else $error("Reserved bits not zero.");

  a_sel_first: assert property (@(posedge CLK) disable iff (!RST_B)
    1'b1 |=> SELECTED_INPUTS[0] == $past(sel0_q < 7'(`TMX_EXT_BUS_W) && EXT_IN_BUS[sel0_q]))
    else $error("First selected input wrong.");

  a_sel_second: assert property (@(posedge CLK) disable iff (!RST_B)
    1'b1 |=> SELECTED_INPUTS[1] == $past(sel1_q < 7'(`TMX_EXT_BUS_W) && EXT_IN_BUS[sel1_q]))
    else $error("Second selected input wrong.");

  a_ts_force: assert property (@(posedge CLK) disable iff (!RST_B)
    TS_REQ && TRACE_BUSY && aux_q[`TMX_AUX_FORCE_TS] |=> TS_INSERT)
    else $error("Forced timestamp missing.");

  a_wp_gap: assert property (@(posedge CLK) disable iff (!RST_B)
    WP_GAP > `TMX_WP_GAP_BYTES && !aux_q[`TMX_AUX_DIS_WP] |=> WP_UPDATE)
    else $error("Waypoint update missing after long gap.");

  a_wp_quiet: assert property (@(posedge CLK) disable iff (!RST_B)
    aux_q[`TMX_AUX_DIS_WP] && !EXC_EVENT && !DBG_ENTRY |=> !WP_UPDATE)
    else $error("Waypoint update while disabled.");

  a_exc_ts: assert property (@(posedge CLK) disable iff (!RST_B)
    EXC_EVENT && !aux_q[`TMX_AUX_DIS_EXC_TS] |=> TS_INSERT)
    else $error("Exception timestamp missing.");

  a_bar_ts: assert property (@(posedge CLK) disable iff (!RST_B)
    BARRIER_EVENT && !aux_q[`TMX_AUX_DIS_BAR_TS] |=> TS_INSERT)
    else $error("Barrier timestamp missing.");

  a_trig_drive: assert property (@(posedge CLK) disable iff (!RST_B)
    itmode_q |=> TRACE_TRIGGER_OUT == $past(trig_q))
    else $error("Trigger not driven from its register.");

  a_ctrlin_read: assert property (@(posedge CLK) disable iff (!RST_B)
    PSEL && !PENABLE && !PWRITE && rd_reg == TMX_R_CTRLIN
    |=> PRDATA == ($past(itmode_q) ?
      {30'h0, $past(TRACE_BUS_FLUSH_VALID), $past(TRACE_BUS_READY)} : 32'h0))
    else $error("Control input read wrong.");

  a_ext_func: assert property (@(posedge CLK) disable iff (!RST_B)
    !itmode_q |=> TRACE_EXTERNAL_OUTPUTS == $past(FN_EXT_OUT))
    else $error("External outputs not functional outside integration mode.");

endmodule : tmx_trace_aux

/* tmx_sink_model.sv */
// Behavioural trace bus sink facing the block's valid output.
// Assumes it shares CLK and the synchronous active-low reset.
module tmx_sink_model
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic valid,
  input wire logic slow,
  input wire logic flush_req,
  output logic ready,
  output logic flush_valid
);
  // ****************
  // Sink handshake
  // ****************
  logic [1:0] wait_q;
  logic tog_q;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wait_q <= 2'h0;
      tog_q <= 1'h0;
    end
    else
    begin
      tog_q <= !tog_q;
      if (!valid)
        wait_q <= slow ? 2'h3 : 2'h0;
      else if (wait_q != 2'h0)
        wait_q <= wait_q - 2'h1;
    end
  end
  // Ready carries no meaning without valid, so it wanders while valid is low.
  assign ready = valid ? (wait_q == 2'h0) : tog_q;
  assign flush_valid = flush_req;
endmodule : tmx_sink_model

/* test_tmx_trace_aux.sv */
// Self-checking bench for the trace aux block over APB.
// Assumes tmx_defines.svh on the include path and the sink model beside it.
`include "tmx_defines.svh"
module test_tmx_trace_aux
  import tmx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Stimulus and checks
  // ****************
  localparam logic [31:0] FN_DATA = 32'h1234_5678;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [87:0] ext_bus = 88'h0;
  logic [8:0] ev = 9'h0;
  logic [8:0] evs [10] = '{9'h180, 9'h080, 9'h140, 9'h060, 9'h010, 9'h008, 9'h004,
    9'h002, 9'h001, 9'h000};
  logic slow = 1'h0;
  logic flush_req = 1'h0;
  logic [3:0] ext_in = 4'hA;
  logic [5:0] aux_v;
  wire [3:0] pol_out;
  tmx_word_type prdata;
  tmx_word_type rd;
  tmx_word_type bus_data;
  logic pready, pslverr, err, ready, flush_valid, trig_out, valid, pwr;
  logic [1:0] sel_in, ext_out;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #25 clk = !clk;
  tmx_trace_aux DUT (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_IN_BUS(ext_bus), .SELECTED_INPUTS(sel_in),
    .TRACE_BUSY(ev[8]), .TS_REQ(ev[7]), .SYNC_REQ(ev[6]), .SYNC_PENDING(ev[5]),
    .FIFO_FULL(ev[4]), .EXC_EVENT(ev[3]), .DBG_ENTRY(ev[2]), .BARRIER_EVENT(ev[1]),
    .WP_GAP(ev[0] ? 16'h1001 : 16'h1000), .TS_INSERT(pol_out[3]),
    .SYNC_INSERT(pol_out[2]), .WP_UPDATE(pol_out[1]), .OVERFLOW_ENTER(pol_out[0]),
    .CORE_POWER_UP_REQUEST(pwr), .FN_EXT_OUT(2'h1), .FN_TRIGGER(1'h0),
    .FN_BUS_DATA(FN_DATA), .FN_BUS_VALID(1'h0), .TRACE_EXTERNAL_INPUTS(ext_in),
    .TRACE_BUS_FLUSH_VALID(flush_valid), .TRACE_BUS_READY(ready),
    .TRACE_EXTERNAL_OUTPUTS(ext_out), .TRACE_TRIGGER_OUT(trig_out),
    .TRACE_BUS_DATA(bus_data), .TRACE_BUS_VALID(valid));
  tmx_sink_model sink (.clk(clk), .rst_b(rst_b), .valid(valid), .slow(slow),
    .flush_req(flush_req), .ready(ready), .flush_valid(flush_valid));
  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // The master holds every field until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(name, exp, rd);
  endtask : rchk
  task automatic chk_fn;
    repeat (2) @(posedge clk);
    #1;
    chk("fn pins", 32'h4, {28'h0, ext_out, trig_out, valid});
    chk("fn data", FN_DATA, bus_data);
  endtask : chk_fn
  function automatic logic [3:0] pol(input logic [5:0] a, input logic [8:0] e);
    logic ts, sy, wp, ov;
    ts = (e[7] & (!e[8] | a[5])) | (e[3] & !a[2]) | (e[1] & !a[1]);
    sy = e[6] & !(e[8] & a[4]);
    wp = (e[0] & !a[3]) | e[3] | e[2];
    ov = e[4] | (e[6] & e[5] & !a[0]);
    return {ts, sy, wp, ov};
  endfunction : pol
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    rchk("aux rst", `TMX_OFS_AUX, 32'h0);
    rchk("sel rst", `TMX_OFS_EXTSEL, 32'h0);
    rchk("pdc rst", `TMX_OFS_PDC, 32'h0);
    rchk("mode rst", `TMX_OFS_ITCTRL, 32'h0);
    rchk("unmapped", 12'h100, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'h1, `TMX_OFS_EXTSEL, 32'hFFFF_FFFF);
    rchk("sel mask", `TMX_OFS_EXTSEL, 32'h7F7F);
    apb(1'h1, `TMX_OFS_AUX, 32'hFFFF_FFFF);
    rchk("aux mask", `TMX_OFS_AUX, 32'h3F);
    apb(1'h1, `TMX_OFS_EXTSEL, 32'h0557);
    ext_bus <= 88'h20;
    repeat (2) @(posedge clk);
    #1;
    chk("sel one", 32'h2, {30'h0, sel_in});
    ext_bus <= {1'h1, 87'h0};
    repeat (2) @(posedge clk);
    #1;
    chk("sel two", 32'h1, {30'h0, sel_in});
    for (int k = 0; k < 7; k++)
    begin
      aux_v = (k == 0) ? 6'h0 : 6'h1 << (k - 1);
      apb(1'h1, `TMX_OFS_AUX, {26'h0, aux_v});
      foreach (evs[i])
      begin
        @(posedge clk);
        ev <= evs[i];
        @(posedge clk);
        ev <= 9'h0;
        #1;
        chk("policy", {28'h0, pol(aux_v, evs[i])}, {28'h0, pol_out});
      end
    end
    apb(1'h1, `TMX_OFS_PDC, 32'hFFFF_FFFF);
    rchk("pdc mask", `TMX_OFS_PDC, 32'h8);
    chk("pwr up", 32'h1, {31'h0, pwr});
    apb(1'h1, `TMX_OFS_MISCOUT, 32'hFFFF_FFFF);
    apb(1'h1, `TMX_OFS_TRIG, 32'hFFFF_FFFF);
    apb(1'h1, `TMX_OFS_DATA, 32'h15);
    apb(1'h1, `TMX_OFS_CTRLOUT, 32'h1);
    chk_fn();
    rchk("in off", `TMX_OFS_MISCIN, 32'h0);
    apb(1'h1, `TMX_OFS_ITCTRL, 32'hFFFF_FFFF);
    rchk("mode", `TMX_OFS_ITCTRL, 32'h1);
    #1;
    chk("ext out", 32'h3, {30'h0, ext_out});
    chk("trigger", 32'h1, {31'h0, trig_out});
    chk("data", 32'h8000_8001, bus_data & 32'h8080_8081);
    apb(1'h1, `TMX_OFS_DATA, 32'h0A);
    repeat (2) @(posedge clk);
    #1;
    chk("data", 32'h0080_0080, bus_data & 32'h8080_8081);
    rchk("misc in", `TMX_OFS_MISCIN, 32'hA);
    ext_in <= 4'h5;
    rchk("misc in", `TMX_OFS_MISCIN, 32'h5);
    rchk("misc out", `TMX_OFS_MISCOUT, 32'h0);
    for (int s = 0; s < 2; s++)
    begin
      slow <= s[0];
      flush_req <= s[0];
      apb(1'h1, `TMX_OFS_CTRLOUT, 32'h0);
      apb(1'h1, `TMX_OFS_CTRLOUT, 32'h1);
      rd = 32'h0;
      for (int n = 0; n < 8 && rd[0] !== 1'h1; n++)
        apb(1'h0, `TMX_OFS_CTRLIN, 32'h0);
      chk("ctrl in", {30'h0, s[0], 1'h1}, rd);
      chk("valid out", 32'h1, {31'h0, valid});
    end
    apb(1'h1, `TMX_OFS_ITCTRL, 32'h0);
    chk_fn();
    @(posedge clk);
    rst_b <= 1'h0;
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    #1;
    chk("pwr rst", 32'h0, {31'h0, pwr});
    rchk("aux rst", `TMX_OFS_AUX, 32'h0);
    rchk("mode rst", `TMX_OFS_ITCTRL, 32'h0);
    wrap_up();
  end
endmodule : test_tmx_trace_aux
